// ==== logic/ext_bus_interface_config.sv ====
// external bus sequencer steered by the configuration byte, with the three bus ports
//
// How it works
// - page-select bit clear: high port muxes upper address/data, low port holds lower address.
// - page-select bit set: high port holds upper address, low port muxes lower address/data.
// - program-store strobe fires only for the range the two select bits choose.
// - select code 0 makes the shared pin address bit 16, codes 1 and 2 the read strobe; code 3 leaves it plain I/O.
// - low port is open drain; a latch bit holding one floats the pin.
// - high port is pulled-up I/O carrying upper address bits through accesses with the page-select bit set, and in the latch phase only with it clear.
// - third port is pulled-up I/O; bit 7 carries read strobe or address bit 16, except under select code 3.
`include "ext_bus_map.svh"
`default_nettype none
module ext_bus_interface_config
    import ext_bus_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // non-volatile configuration byte
    input wire logic [7:0] config_byte_in,
    // access requests from the core
    input wire logic acc_req,
    input wire bus_req_t acc_cmd,
    output logic acc_ready,
    output logic acc_done,
    output logic [7:0] acc_rdata,
    // bus ports
    input wire logic [7:0] low_bus_port_in,
    output port_drive_t low_bus_port,
    input wire logic [7:0] high_bus_port_in,
    output port_drive_t high_bus_port,
    input wire logic [7:0] third_general_port_in,
    output port_drive_t third_general_port,
    output logic program_store_strobe_n,
    output logic addr_latch_enable
);
    logic [31:0] pins_sync;
    logic [7:0] low_sync;
    logic [7:0] high_sync;
    logic [7:0] third_sync;
    logic [7:0] config_sync;

    logic [7:0] ext_bus_config_byte;
    logic [7:0] next_config;
    logic loaded;
    logic next_loaded;
    logic [1:0] settle;
    logic [1:0] next_settle;
    logic [7:0] low_latch;
    logic [7:0] next_low_latch;
    logic [7:0] high_latch;
    logic [7:0] next_high_latch;
    logic [7:0] third_latch;
    logic [7:0] next_third_latch;
    logic [7:0] next_reg_rdata;

    bus_state_t state;
    bus_state_t next_state;
    bus_req_t req;
    bus_req_t next_req;
    logic [1:0] cnt;
    logic [1:0] next_cnt;
    logic next_done;
    logic [7:0] next_acc_rdata;
    pins_t pins;
    pins_t next_pins;

    pin_sync #(.WIDTH(32)) u_sync (
        .clock(clock),
        .resetn(resetn),
        .async_in({config_byte_in, third_general_port_in, high_bus_port_in, low_bus_port_in}),
        .sync_out(pins_sync)
    );

    assign low_sync = pins_sync[7:0];
    assign high_sync = pins_sync[15:8];
    assign third_sync = pins_sync[23:16];
    assign config_sync = pins_sync[31:24];

    function automatic logic [1:0] wait_count(input logic [7:0] cfg);
        return ~{cfg[`BIT_WAIT1_N], cfg[`BIT_WAIT0_N]};
    endfunction

    function automatic logic program_store_strobe_n_covers(input logic [7:0] cfg, input bus_req_t rq);
        logic r;
        r = 1'b0;
        case ({cfg[`BIT_SEL_HI], cfg[`BIT_SEL_LO]})
            2'h0: r = (rq.kind != KIND_WRITE);
            2'h1: r = (rq.kind == KIND_FETCH);
            2'h2: r = (rq.kind == KIND_FETCH) || (rq.kind == KIND_READ && rq.addr[16]);
            default: r = (rq.kind != KIND_WRITE);
        endcase
        return r;
    endfunction

    function automatic logic pin_is_a16(input logic [7:0] cfg);
        return {cfg[`BIT_SEL_HI], cfg[`BIT_SEL_LO]} == 2'h0;
    endfunction

    function automatic logic pin_is_strobe(input logic [7:0] cfg);
        return ({cfg[`BIT_SEL_HI], cfg[`BIT_SEL_LO]} == 2'h1) || ({cfg[`BIT_SEL_HI], cfg[`BIT_SEL_LO]} == 2'h2);
    endfunction

    // pin levels for a given bus state; computed from next values so pins line up with the state register
    function automatic pins_t drive_pins(input bus_state_t st, input bus_req_t rq, input logic [7:0] cfg,
                                         input logic [7:0] lat_lo, input logic [7:0] lat_hi,
                                         input logic [7:0] lat_th);
        pins_t p;
        logic busy;
        logic wr_act;
        logic rd_act;
        busy = (st == ST_LATCH) || (st == ST_STROBE);
        wr_act = (st == ST_STROBE) && (rq.kind == KIND_WRITE);
        rd_act = (st == ST_STROBE) && (rq.kind != KIND_WRITE);
        // idle: a one floats the pin, a zero pulls it low
        p.low.value = 8'h00;
        p.low.oe_n = lat_lo;
        p.high.value = 8'h00;
        p.high.oe_n = lat_hi;
        p.third.value = 8'h00;
        p.third.oe_n = lat_th;
        p.program_store_strobe_n_n = 1'b1;
        p.ale = 1'b0;
        if (busy) begin
            p.ale = (st == ST_LATCH);
            if (!cfg[`BIT_PAGE_N]) begin
                p.low.value = rq.addr[7:0];
                p.low.oe_n = 8'h00;
                p.high.value = wr_act ? rq.wdata : rq.addr[15:8];
                p.high.oe_n = rd_act ? 8'hFF : 8'h00;
            end else begin
                p.high.value = rq.addr[15:8];
                p.high.oe_n = 8'h00;
                p.low.value = wr_act ? rq.wdata : rq.addr[7:0];
                p.low.oe_n = rd_act ? 8'hFF : 8'h00;
            end
            p.program_store_strobe_n_n = ~(rd_act && program_store_strobe_n_covers(cfg, rq));
            if (pin_is_a16(cfg)) begin
                p.third.value[`BIT_READ_PIN] = rq.addr[16];
                p.third.oe_n[`BIT_READ_PIN] = 1'b0;
            end else if (pin_is_strobe(cfg)) begin
                p.third.value[`BIT_READ_PIN] = ~(rd_act && !program_store_strobe_n_covers(cfg, rq));
                p.third.oe_n[`BIT_READ_PIN] = 1'b0;
            end
            p.third.value[`BIT_WRITE_PIN] = ~wr_act;
            p.third.oe_n[`BIT_WRITE_PIN] = 1'b0;
        end
        return p;
    endfunction

    // configuration capture and register file
    always_comb begin
        next_config = ext_bus_config_byte;
        next_loaded = loaded;
        next_settle = settle;
        next_low_latch = low_latch;
        next_high_latch = high_latch;
        next_third_latch = third_latch;
        next_reg_rdata = 8'h00;
        // the byte is sampled only after the synchroniser has filled, then frozen
        if (!loaded) begin
            if (settle == `CONFIG_SETTLE) begin
                next_config = config_sync;
                next_loaded = 1'b1;
            end else begin
                next_settle = settle + 2'h1;
            end
        end
        if (reg_write) begin
            case (reg_addr)
                `OFF_LOW_LATCH: next_low_latch = reg_wdata;
                `OFF_HIGH_LATCH: next_high_latch = reg_wdata;
                `OFF_THIRD_LATCH: next_third_latch = reg_wdata;
                default: next_low_latch = low_latch;
            endcase
        end
        if (reg_read) begin
            case (reg_addr)
                `OFF_CONFIG: next_reg_rdata = ext_bus_config_byte;
                `OFF_LOW_LATCH: next_reg_rdata = low_latch;
                `OFF_HIGH_LATCH: next_reg_rdata = high_latch;
                `OFF_THIRD_LATCH: next_reg_rdata = third_latch;
                `OFF_STATUS: next_reg_rdata = {3'h0, wait_count(ext_bus_config_byte),
                                               ext_bus_config_byte[`BIT_RESERVED], loaded, (state != ST_IDLE)};
                `OFF_LOW_PINS: next_reg_rdata = low_sync;
                `OFF_HIGH_PINS: next_reg_rdata = high_sync;
                `OFF_THIRD_PINS: next_reg_rdata = third_sync;
                default: next_reg_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ext_bus_config_byte <= `RESET_CONFIG;
            loaded <= 1'b0;
            settle <= 2'h0;
            low_latch <= `RESET_LATCH;
            high_latch <= `RESET_LATCH;
            third_latch <= `RESET_LATCH;
            reg_rdata <= `RESET_DATA;
        end else begin
            ext_bus_config_byte <= next_config;
            loaded <= next_loaded;
            settle <= next_settle;
            low_latch <= next_low_latch;
            high_latch <= next_high_latch;
            third_latch <= next_third_latch;
            reg_rdata <= next_reg_rdata;
        end
    end

    // bus sequencer
    assign acc_ready = loaded && (state == ST_IDLE);

    always_comb begin
        next_state = state;
        next_req = req;
        next_cnt = cnt;
        next_done = 1'b0;
        next_acc_rdata = acc_rdata;
        case (state)
            ST_IDLE: begin
                if (acc_req && acc_ready) begin
                    next_req = acc_cmd;
                    next_state = ST_LATCH;
                    next_cnt = ext_bus_config_byte[`BIT_LATCH_EXT_N] ? `LATCH_SHORT_CYCLES - 2'h1
                                                                      : `LATCH_LONG_CYCLES - 2'h1;
                end
            end
            ST_LATCH: begin
                if (cnt == 2'h0) begin
                    next_state = ST_STROBE;
                    next_cnt = wait_count(ext_bus_config_byte);
                end else begin
                    next_cnt = cnt - 2'h1;
                end
            end
            ST_STROBE: begin
                if (cnt == 2'h0) begin
                    next_state = ST_DONE;
                    next_done = 1'b1;
                    if (req.kind != KIND_WRITE) begin
                        next_acc_rdata = ext_bus_config_byte[`BIT_PAGE_N] ? low_sync : high_sync;
                    end
                end else begin
                    next_cnt = cnt - 2'h1;
                end
            end
            ST_DONE: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        next_pins = drive_pins(next_state, next_req, next_config, next_low_latch, next_high_latch,
                               next_third_latch);
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
            req <= '0;
            cnt <= 2'h0;
            acc_done <= 1'b0;
            acc_rdata <= `RESET_DATA;
            pins <= '{low: '{value: 8'h00, oe_n: 8'hFF}, high: '{value: 8'h00, oe_n: 8'hFF},
                      third: '{value: 8'h00, oe_n: 8'hFF}, program_store_strobe_n_n: 1'b1, ale: 1'b0};
        end else begin
            state <= next_state;
            req <= next_req;
            cnt <= next_cnt;
            acc_done <= next_done;
            acc_rdata <= next_acc_rdata;
            pins <= next_pins;
        end
    end

    assign low_bus_port = pins.low;
    assign high_bus_port = pins.high;
    assign third_general_port = pins.third;
    assign program_store_strobe_n = pins.program_store_strobe_n_n;
    assign addr_latch_enable = pins.ale;

    // helper: length of the strobe phase just finished
    logic [2:0] strobe_len;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            strobe_len <= 3'h0;
        end else if (state == ST_STROBE) begin
            strobe_len <= strobe_len + 3'h1;
        end else if (state == ST_IDLE) begin
            strobe_len <= 3'h0;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence s_start;
        acc_req && acc_ready;
    endsequence
    sequence s_short_latch;
        state == ST_LATCH ##1 state == ST_STROBE;
    endsequence
    sequence s_long_latch;
        (state == ST_LATCH) [*3] ##1 state == ST_STROBE;
    endsequence

    property p_page_low_addr;
        (state == ST_STROBE && !ext_bus_config_byte[`BIT_PAGE_N]) |-> (low_bus_port.value == req.addr[7:0]
            && low_bus_port.oe_n == 8'h00);
    endproperty
    a_page_low_addr: assert property (p_page_low_addr) else $error("page mode low port lost address");

    property p_page_high_data;
        (state == ST_STROBE && !ext_bus_config_byte[`BIT_PAGE_N] && req.kind == KIND_WRITE)
            |-> high_bus_port.value == req.wdata;
    endproperty
    a_page_high_data: assert property (p_page_high_data) else $error("page write data not on high port");

    property p_nonpage_high_addr;
        (state == ST_STROBE && ext_bus_config_byte[`BIT_PAGE_N]) |-> high_bus_port.value == req.addr[15:8];
    endproperty
    a_nonpage_high_addr: assert property (p_nonpage_high_addr) else $error("high port lost address");

    property p_nonpage_low_data;
        (state == ST_STROBE && ext_bus_config_byte[`BIT_PAGE_N] && req.kind != KIND_WRITE)
            |-> low_bus_port.oe_n == 8'hFF;
    endproperty
    a_nonpage_low_data: assert property (p_nonpage_low_data) else $error("read kept low port driven");

    property p_program_store_strobe_n_range;
        !program_store_strobe_n |-> (state == ST_STROBE && program_store_strobe_n_covers(ext_bus_config_byte, req));
    endproperty
    a_program_store_strobe_n_range: assert property (p_program_store_strobe_n_range) else $error("program-store strobe outside its range");

    property p_a16_pin;
        (state == ST_LATCH && pin_is_a16(ext_bus_config_byte))
            |-> third_general_port.value[`BIT_READ_PIN] == req.addr[16];
    endproperty
    a_a16_pin: assert property (p_a16_pin) else $error("shared pin does not carry address bit 16");

    property p_float;
        (state == ST_IDLE) |-> (low_bus_port.oe_n == low_latch && high_bus_port.oe_n == high_latch);
    endproperty
    a_float: assert property (p_float) else $error("idle port does not follow its latch");

    property p_high_addr;
        (state == ST_LATCH) |-> (high_bus_port.value == req.addr[15:8] && addr_latch_enable);
    endproperty
    a_high_addr: assert property (p_high_addr) else $error("high port lacks upper address in latch phase");

    property p_read_strobe;
        (state == ST_STROBE && pin_is_strobe(ext_bus_config_byte) && req.kind == KIND_READ
            && !program_store_strobe_n_covers(ext_bus_config_byte, req)) |-> !third_general_port.value[`BIT_READ_PIN];
    endproperty
    a_read_strobe: assert property (p_read_strobe) else $error("read strobe missing on third port");

    property p_wait_len;
        (state == ST_DONE) |-> strobe_len == {1'b0, wait_count(ext_bus_config_byte)} + 3'h1;
    endproperty
    a_wait_len: assert property (p_wait_len) else $error("strobe length does not match wait states");

    property p_latch_len;
        s_start |=> (if (ext_bus_config_byte[`BIT_LATCH_EXT_N]) s_short_latch else s_long_latch);
    endproperty
    a_latch_len: assert property (p_latch_len) else $error("address latch phase has wrong length");
endmodule
`default_nettype wire

// ==== logic/ext_bus_map.svh ====
// register offsets, field positions, reset values and timing counts of the external bus block
`ifndef EXT_BUS_MAP_SVH
`define EXT_BUS_MAP_SVH

`define OFF_CONFIG 8'h00
`define OFF_LOW_LATCH 8'h04
`define OFF_HIGH_LATCH 8'h08
`define OFF_THIRD_LATCH 8'h0C
`define OFF_STATUS 8'h10
`define OFF_LOW_PINS 8'h14
`define OFF_HIGH_PINS 8'h18
`define OFF_THIRD_PINS 8'h1C

`define BIT_RESERVED 7
`define BIT_WAIT1_N 6
`define BIT_WAIT0_N 5
`define BIT_LATCH_EXT_N 4
`define BIT_SEL_HI 3
`define BIT_SEL_LO 2
`define BIT_PAGE_N 1
`define BIT_SRC 0

`define BIT_READ_PIN 7
`define BIT_WRITE_PIN 6

`define RESET_LATCH 8'hFF
`define RESET_CONFIG 8'hFF
`define RESET_DATA 8'h00

`define LATCH_SHORT_CYCLES 2'h1
`define LATCH_LONG_CYCLES 2'h3
`define CONFIG_SETTLE 2'h3

`endif

// ==== logic/ext_bus_pkg.sv ====
// types shared by the external bus block
`default_nettype none
package ext_bus_pkg;
    typedef enum logic [1:0] {KIND_FETCH, KIND_READ, KIND_WRITE} access_kind_t;
    typedef enum {ST_IDLE, ST_LATCH, ST_STROBE, ST_DONE} bus_state_t;
    typedef struct packed {
        access_kind_t kind;
        logic [16:0] addr;
        logic [7:0] wdata;
    } bus_req_t;
    typedef struct packed {
        logic [7:0] value;
        logic [7:0] oe_n;
    } port_drive_t;
    typedef struct packed {
        port_drive_t low;
        port_drive_t high;
        port_drive_t third;
        logic program_store_strobe_n_n;
        logic ale;
    } pins_t;
endpackage
`default_nettype wire

// ==== logic/pin_sync.sv ====
// two-stage synchroniser for pin inputs
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // pins
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule
`default_nettype wire

// ==== tb/ext_bus_interface_config_tb_top.sv ====
// self-checking bench for the external bus block
`include "ext_bus_map.svh"
`default_nettype none
module ext_bus_interface_config_tb_top
    import ext_bus_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic rd; logic [7:0] data;} note_t;
    logic clock, resetn, reg_write, reg_read, acc_req, rd_seen;
    logic [7:0] reg_addr, reg_wdata, config_byte_in, cfg, d;
    bus_req_t acc_cmd;
    wire logic [7:0] reg_rdata, acc_rdata, low_lvl, high_lvl, third_lvl;
    wire logic acc_ready, acc_done, program_store_strobe_n, addr_latch_enable;
    port_drive_t low_bus_port, high_bus_port, third_general_port;
    logic [16:0] a;
    logic [7:0] shadow [int];
    note_t reg_q[$];
    note_t acc_q[$];
    note_t e;
    int err_count = 0;
    int comparisons = 0;
    ext_bus_interface_config ext_bus_interface_config_inst (.clock(clock), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .config_byte_in(config_byte_in), .acc_req(acc_req), .acc_cmd(acc_cmd),
        .acc_ready(acc_ready), .acc_done(acc_done), .acc_rdata(acc_rdata), .low_bus_port_in(low_lvl),
        .low_bus_port(low_bus_port), .high_bus_port_in(high_lvl), .high_bus_port(high_bus_port),
        .third_general_port_in(third_lvl), .third_general_port(third_general_port),
        .program_store_strobe_n(program_store_strobe_n), .addr_latch_enable(addr_latch_enable));
    ext_mem_model ext_mem_model_inst (.clock(clock), .page_n(cfg[1]), .sel(cfg[3:2]),
        .low_bus_port(low_bus_port), .high_bus_port(high_bus_port), .third_general_port(third_general_port),
        .program_store_strobe_n(program_store_strobe_n), .addr_latch_enable(addr_latch_enable),
        .low_lvl(low_lvl), .high_lvl(high_lvl), .third_lvl(third_lvl));
    always #4 clock = ~clock;
    task automatic check8(input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic reg_wr(input logic [7:0] ad, input logic [7:0] wd);
        @(posedge clock);
        reg_addr <= ad;
        reg_wdata <= wd;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] ad, input logic [7:0] exp);
        @(posedge clock);
        reg_addr <= ad;
        reg_read <= 1'b1;
        reg_q.push_back('{1'b1, exp});
        @(posedge clock);
        reg_read <= 1'b0;
    endtask
    task automatic access(input access_kind_t k, input logic [16:0] ad, input logic [7:0] wd);
        bus_req_t c;
        logic [16:0] idx;
        logic [1:0] w;
        logic pcov;
        int n, lat, sc, ps, rs, ws;
        c.kind = k;
        c.addr = ad;
        c.wdata = wd;
        w = ~cfg[6:5];
        lat = cfg[4] ? 1 : 3;
        sc = 1 + w;
        idx = {cfg[3:2] == 2'b00 ? ad[16] : 1'b0, ad[15:0]};
        pcov = k == KIND_FETCH
            || (k == KIND_READ && (cfg[3:2] inside {2'b00, 2'b11} || (cfg[3:2] == 2'b10 && ad[16])));
        if (k == KIND_WRITE) begin
            shadow[idx] = wd;
        end
        acc_q.push_back('{k != KIND_WRITE,
            shadow.exists(idx) ? shadow[idx] : idx[7:0] ^ idx[15:8] ^ {7'h0, idx[16]} ^ 8'h3C});
        @(posedge clock);
        acc_req <= 1'b1;
        acc_cmd <= c;
        @(negedge clock);
        for (n = 0; n < 50 && acc_ready !== 1'b1; n++) @(negedge clock);
        @(posedge clock);
        acc_req <= 1'b0;
        ps = 0;
        rs = 0;
        ws = 0;
        for (n = 1; n < 30; n++) begin
            @(negedge clock);
            if (acc_done === 1'b1) break;
            if (addr_latch_enable === 1'b1) begin
                check8(ad[7:0], low_bus_port.value);
                check8(ad[15:8], high_bus_port.value);
            end
            if (n > lat) begin
                check8(cfg[1] ? ad[15:8] : ad[7:0],
                       cfg[1] ? high_bus_port.value : low_bus_port.value);
                if (cfg[3:2] == 2'b00) check8({7'h0, ad[16]}, {7'h0, third_general_port.value[7]});
            end
            if (program_store_strobe_n === 1'b0) ps++;
            if (cfg[3:2] inside {2'b01, 2'b10} && third_general_port.value[7] === 1'b0) rs++;
            if (third_general_port.value[6] === 1'b0) begin
                ws++;
                check8(wd, cfg[1] ? low_bus_port.value : high_bus_port.value);
            end
        end
        check8(8'(n), 8'(lat + sc + 1));
        check8(8'(ps), pcov ? 8'(sc) : 8'h00);
        check8(8'(rs), (k == KIND_READ && !pcov) ? 8'(sc) : 8'h00);
        check8(8'(ws), k == KIND_WRITE ? 8'(sc) : 8'h00);
    endtask
    // results are judged apart from the driver, in order of arrival
    always @(negedge clock) begin
        if (rd_seen && reg_q.size() > 0) begin
            e = reg_q.pop_front();
            check8(e.data, reg_rdata);
        end
        rd_seen = reg_read;
        if (acc_done === 1'b1 && acc_q.size() > 0) begin
            e = acc_q.pop_front();
            if (e.rd) check8(e.data, acc_rdata);
        end
    end
    initial begin
        repeat (30000) @(posedge clock);
        err_count++;
        report_and_stop();
    end
    initial begin
        clock = 1'b0;
        resetn = 1'b0;
        rd_seen = 1'b0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        acc_req = 1'b0;
        acc_cmd = '0;
        cfg = 8'hFF;
        config_byte_in = 8'hFF;
        void'($urandom(32'h5699));
        for (int t = 0; t < 8; t++) begin
            // the config is captured once, so each setting needs its own reset
            cfg = {1'b1, 1'b0, 1'($urandom), 1'($urandom), 2'(t), 1'(t >> 2), 1'($urandom)};
            @(posedge clock);
            resetn <= 1'b0;
            config_byte_in <= cfg;
            repeat (20) @(posedge clock);
            resetn <= 1'b1;
            repeat (6) @(posedge clock);
            reg_rd(`OFF_CONFIG, cfg);
            reg_wr(`OFF_CONFIG, 8'h00);
            reg_rd(`OFF_CONFIG, cfg);
            reg_rd(`OFF_STATUS, {3'h0, ~cfg[6:5], cfg[7], 2'b10});
            reg_rd(`OFF_LOW_LATCH, `RESET_LATCH);
            reg_rd(8'h20, 8'h00);
            a = 17'($urandom);
            d = 8'($urandom);
            access(KIND_WRITE, a, d);
            access(KIND_READ, a, 8'h00);
            access(KIND_FETCH, a ^ 17'h10000, 8'h00);
            access(KIND_READ, {1'b1, a[15:0] ^ 16'h00F0}, 8'h00);
            access(KIND_READ, {1'b0, a[15:0] ^ 16'h0F00}, 8'h00);
            d = 8'($urandom);
            reg_wr(`OFF_HIGH_LATCH, d);
            // strobe bits of the third port stay high so the memory sees no stray cycle
            reg_wr(`OFF_THIRD_LATCH, d | 8'hC0);
            reg_wr(`OFF_LOW_LATCH, d);
            repeat (4) @(posedge clock);
            @(negedge clock);
            check8(d, low_bus_port.oe_n);
            check8(8'h00, low_bus_port.value);
            reg_rd(`OFF_HIGH_PINS, d);
            reg_rd(`OFF_THIRD_PINS, d | 8'hC0);
            reg_rd(`OFF_LOW_LATCH, d);
            reg_wr(`OFF_LOW_LATCH, `RESET_LATCH);
            $display("test cfg %h done", cfg);
        end
        report_and_stop();
    end
endmodule
`default_nettype wire

// ==== tb/ext_mem_model.sv ====
// external code and data memory model standing on the bus ports
`default_nettype none
module ext_mem_model
    import ext_bus_pkg::*;
(
    // clock
    input wire logic clock,
    // board strapping that matches the configuration byte
    input wire logic page_n,
    input wire logic [1:0] sel,
    // device pins
    input wire port_drive_t low_bus_port,
    input wire port_drive_t high_bus_port,
    input wire port_drive_t third_general_port,
    input wire logic program_store_strobe_n,
    input wire logic addr_latch_enable,
    // resolved pin levels
    output logic [7:0] low_lvl,
    output logic [7:0] high_lvl,
    output logic [7:0] third_lvl
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:131071];
    logic [16:0] addr;
    logic [7:0] flt;
    logic rd_strobe;
    logic wr_strobe;
    logic drive;
    initial begin
        flt = 8'h5A;
        addr = 17'h00000;
        for (int i = 0; i < 131072; i++) begin
            mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'(i >> 16) ^ 8'h3C;
        end
    end
    // shared pin is a read strobe only for the two middle select codes
    assign rd_strobe = (sel == 2'b01 || sel == 2'b10) && !third_general_port.oe_n[7]
        && !third_general_port.value[7];
    assign wr_strobe = !third_general_port.oe_n[6] && !third_general_port.value[6];
    assign drive = !program_store_strobe_n || rd_strobe;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            low_lvl[i] = !low_bus_port.oe_n[i] ? low_bus_port.value[i] : flt[i];
            high_lvl[i] = !high_bus_port.oe_n[i] ? high_bus_port.value[i] : 1'b1;
            third_lvl[i] = !third_general_port.oe_n[i] ? third_general_port.value[i] : 1'b1;
        end
        if (drive && page_n) begin
            low_lvl = mem[addr];
        end
        if (drive && !page_n) begin
            high_lvl = mem[addr];
        end
    end
    // a floating open-drain line shows no stale value: it flips every cycle
    always @(negedge clock) begin
        flt <= ~low_lvl;
        if (addr_latch_enable) begin
            addr <= {sel == 2'b00 ? third_general_port.value[7] : 1'b0, high_lvl, low_lvl};
        end
        if (wr_strobe) begin
            mem[addr] <= page_n ? low_lvl : high_lvl;
        end
    end
endmodule
`default_nettype wire
